// File: logic/csd_pkg.sv
// Purpose: Shared constants and types for the configuration strap decoder
// Assumes: 200 MHz mclk; pins are probed with switchable weak pull resistors
// Notes:   Register offsets are byte addresses on the plain register port
package csd_pkg;

   // Clock rate and probe timing
   localparam int unsigned CLK_PERIOD_PS  = 5000;       // 200 MHz mclk
   localparam int unsigned SETTLE_TIME_NS = 100;        // Weak pull settle time
   // Least time, so round up to whole cycles
   localparam int unsigned SETTLE_CYCLES  =
      (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned CNT_W          = 16;         // Settle counter width

   // Register bus geometry
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned DATA_W         = 32;
   localparam logic [7:0]  OFS_CTRL       = 8'h00;      // Control register
   localparam logic [7:0]  OFS_STATUS     = 8'h04;      // Decoded strap status

   // Control field positions and reset values
   localparam int unsigned CTRL_SCAN_BIT  = 0;          // Pin probing enable
   localparam logic        CTRL_SCAN_RST  = 1'b1;

   // Status field positions
   localparam int unsigned ST_MODE_LSB    = 0;          // Mode pin state [1:0]
   localparam int unsigned ST_AMP_LSB     = 2;          // Amplitude pin state [3:2]
   localparam int unsigned ST_EDGE_LSB    = 4;          // Edge pin state [5:4]
   localparam int unsigned ST_VALID_BIT   = 6;          // Decode complete
   localparam int unsigned ST_SERIAL_BIT  = 7;          // Serial control active

   // Pin input vector positions
   localparam int unsigned PIN_MODE       = 0;
   localparam int unsigned PIN_AMP        = 1;
   localparam int unsigned PIN_EDGE       = 2;
   localparam int unsigned PIN_CS         = 3;
   localparam int unsigned PIN_N          = 4;

   // Resolved level of one three-state pin
   typedef enum logic [1:0] {
      PS_LOW,
      PS_HIGH,
      PS_FLOAT,
      PS_UNKNOWN
   } csd_pin_state_t;

endpackage : csd_pkg

// File: logic/csd_strap_decoder.sv
// Purpose: Decode the three-state control pins into converter configuration
// Assumes: Pins are asynchronous board straps or an external serial host
// Notes:   Mode, amplitude and edge pins are probed with weak pull-up then pull-down to find floats; cs is not
//
// Function
// - Pin mode: serial idle, pins set everything
// - Mode pin driven selects pin mode; float serial
// - Mode low 650 mV range, high 870 mV
// - Amplitude pin low 0.50 V, high 0.70 V
// - Edge pin low falling, high rising
// - Edge pin floating gives double data rate
// - Serial mode: amp clock, edge data, cs
`timescale 1ns/1ps
module csd_strap_decoder #(
   parameter int unsigned SETTLE = csd_pkg::SETTLE_CYCLES
) (
   input  wire logic                        mclk,
   input  wire logic                        rst_b,
   input  wire logic                        ce,
   // Configuration pins
   input  wire logic                        mode_pin,
   input  wire logic                        amp_pin,
   input  wire logic                        edge_pin,
   input  wire logic                        cs_pin,
   // Weak bias controls for the probed pins
   output logic                             mode_pull_up_en,
   output logic                             mode_pull_dn_en,
   output logic                             amp_pull_up_en,
   output logic                             amp_pull_dn_en,
   output logic                             edge_pull_up_en,
   output logic                             edge_pull_dn_en,
   // Register port
   input  wire logic [csd_pkg::ADDR_W-1:0]  reg_addr,
   input  wire logic [csd_pkg::DATA_W-1:0]  reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [csd_pkg::DATA_W-1:0]  reg_rdata,
   // Decoded configuration
   output logic                             config_valid,
   output logic                             serial_mode,
   output logic                             range_high,
   output logic                             swing_high,
   output logic                             edge_rising,
   output logic                             ddr_enable,
   // Serial interface toward the register engine
   output logic                             serial_clock,
   output logic                             serial_data_input,
   output logic                             serial_chip_select_b
);
   import csd_pkg::*;

   // Pin synchronisers
   logic [PIN_N-1:0]       meta_q,  meta_d;      // First stage, read only by second
   logic [PIN_N-1:0]       sync_q,  sync_d;      // Second stage, safe to use

   // Control register
   logic                   scan_q,  scan_d;      // Probing enable

   // Read data register
   logic [DATA_W-1:0]      rdata_q, rdata_d;

   // Decoded configuration registers
   logic                   valid_q,  valid_d;
   logic                   serial_q, serial_d;
   logic                   range_q,  range_d;
   logic                   swing_q,  swing_d;
   logic                   rise_q,   rise_d;
   logic                   ddr_q,    ddr_d;

   // Serial pass-through registers
   logic                   sclk_q,   sclk_d;
   logic                   sdat_q,   sdat_d;
   logic                   csel_b_q, csel_b_d;

   // Resolver results
   csd_pin_state_t         mode_st,  amp_st,  edge_st;
   logic                   mode_vld, amp_vld, edge_vld;
   logic                   mode_driven;          // Mode pin is strapped
   logic                   side_en;              // Probe amplitude and edge pins

   // Synchroniser next values
   always_comb begin
      meta_d = {cs_pin, edge_pin, amp_pin, mode_pin};
      sync_d = meta_q;
   end

   // Synchroniser flops
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         meta_q <= '0;
         sync_q <= '0;
      end else if (ce) begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   // Mode pin must be resolved before the others mean anything
   assign mode_driven = mode_vld && (mode_st == PS_LOW || mode_st == PS_HIGH);
   // In serial mode the shared pins carry traffic, so never bias them
   assign side_en     = scan_q && mode_driven;

   // Mode-select pin, probed whenever scan_q is set
   csd_strap_resolver #(
      .SETTLE      (SETTLE)
   ) u_mode (
      .mclk        (mclk),
      .rst_b       (rst_b),
      .ce          (ce),
      .enable      (scan_q),
      .pin_sync    (sync_q[PIN_MODE]),
      .pull_up_en  (mode_pull_up_en),
      .pull_dn_en  (mode_pull_dn_en),
      .pin_state   (mode_st),
      .state_valid (mode_vld)
   );

   // Output-amplitude pin
   csd_strap_resolver #(
      .SETTLE      (SETTLE)
   ) u_amp (
      .mclk        (mclk),
      .rst_b       (rst_b),
      .ce          (ce),
      .enable      (side_en),
      .pin_sync    (sync_q[PIN_AMP]),
      .pull_up_en  (amp_pull_up_en),
      .pull_dn_en  (amp_pull_dn_en),
      .pin_state   (amp_st),
      .state_valid (amp_vld)
   );

   // Output-edge pin
   csd_strap_resolver #(
      .SETTLE      (SETTLE)
   ) u_edge (
      .mclk        (mclk),
      .rst_b       (rst_b),
      .ce          (ce),
      .enable      (side_en),
      .pin_sync    (sync_q[PIN_EDGE]),
      .pull_up_en  (edge_pull_up_en),
      .pull_dn_en  (edge_pull_dn_en),
      .pin_state   (edge_st),
      .state_valid (edge_vld)
   );

   // Configuration decode; selections only move on a complete result
   always_comb begin
      valid_d  = valid_q;
      serial_d = serial_q;
      range_d  = range_q;
      swing_d  = swing_q;
      rise_d   = rise_q;
      ddr_d    = ddr_q;
      if (mode_vld && mode_st == PS_FLOAT) begin
         // Serial control; pin-set fields keep their last value
         serial_d = 1'b1;
         valid_d  = 1'b1;
      end else if (mode_driven) begin
         serial_d = 1'b0;
         range_d  = (mode_st == PS_HIGH);
         if (amp_vld && edge_vld) begin
            valid_d = 1'b1;
            // Floating amplitude has no meaning: hold last swing
            if (amp_st != PS_FLOAT) begin
               swing_d = (amp_st == PS_HIGH);
            end
            if (edge_st == PS_FLOAT) begin
               // Both edges launch data; edge choice ignored
               ddr_d  = 1'b1;
            end else begin
               ddr_d  = 1'b0;
               rise_d = (edge_st == PS_HIGH);
            end
         end
      end
   end

   // Configuration registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         valid_q  <= 1'b0;
         serial_q <= 1'b0;
         range_q  <= 1'b0;
         swing_q  <= 1'b0;
         rise_q   <= 1'b0;
         ddr_q    <= 1'b0;
      end else if (ce) begin
         valid_q  <= valid_d;
         serial_q <= serial_d;
         range_q  <= range_d;
         swing_q  <= swing_d;
         rise_q   <= rise_d;
         ddr_q    <= ddr_d;
      end
   end

   // Serial pins pass only in serial mode; otherwise held idle
   always_comb begin
      if (serial_q) begin
         sclk_d  = sync_q[PIN_AMP];
         sdat_d  = sync_q[PIN_EDGE];
         csel_b_d = sync_q[PIN_CS];
      end else begin
         // Deselected so the serial engine sees no traffic
         sclk_d  = 1'b0;
         sdat_d  = 1'b0;
         csel_b_d = 1'b1;
      end
   end

   // Serial pass-through registers
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sclk_q  <= 1'b0;
         sdat_q  <= 1'b0;
         csel_b_q <= 1'b1;
      end else if (ce) begin
         sclk_q  <= sclk_d;
         sdat_q  <= sdat_d;
         csel_b_q <= csel_b_d;
      end
   end

   // Register writes and read data capture
   always_comb begin
      scan_d  = scan_q;
      rdata_d = '0;
      if (reg_wr && reg_addr == OFS_CTRL) begin
         scan_d = reg_wdata[CTRL_SCAN_BIT];
      end
      if (reg_rd) begin
         case (reg_addr)
            OFS_CTRL: begin
               rdata_d[CTRL_SCAN_BIT] = scan_q;
            end
            OFS_STATUS: begin
               rdata_d[ST_MODE_LSB +: 2] = mode_st;
               rdata_d[ST_AMP_LSB  +: 2] = amp_st;
               rdata_d[ST_EDGE_LSB +: 2] = edge_st;
               rdata_d[ST_VALID_BIT]     = valid_q;
               rdata_d[ST_SERIAL_BIT]    = serial_q;
            end
            default: begin
               // Unmapped addresses read as zero
               rdata_d = '0;
            end
         endcase
      end
   end

   // Register flops; read data stands one cycle only
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         scan_q  <= CTRL_SCAN_RST;
         rdata_q <= '0;
      end else if (ce) begin
         scan_q  <= scan_d;
         rdata_q <= rdata_d;
      end
   end

   // Configuration, serial and read data outputs straight from flops
   assign config_valid         = valid_q;
   assign serial_mode          = serial_q;
   assign range_high           = range_q;
   assign swing_high           = swing_q;
   assign edge_rising          = rise_q;
   assign ddr_enable           = ddr_q;
   assign serial_clock         = sclk_q;
   assign serial_data_input    = sdat_q;
   assign serial_chip_select_b = csel_b_q;
   assign reg_rdata            = rdata_q;

endmodule : csd_strap_decoder

// File: logic/csd_strap_resolver.sv
// Purpose: Resolve one configuration pin into driven low, driven high or floating
// Assumes: Pin input already synchronised; pull outputs bias the pad weakly
// Notes:   A floating pin follows the applied pull, a driven pin ignores it
`timescale 1ns/1ps
module csd_strap_resolver #(
   parameter int unsigned SETTLE = csd_pkg::SETTLE_CYCLES
) (
   input  wire logic                    mclk,
   input  wire logic                    rst_b,
   input  wire logic                    ce,
   input  wire logic                    enable,
   input  wire logic                    pin_sync,
   output logic                         pull_up_en,
   output logic                         pull_dn_en,
   output csd_pkg::csd_pin_state_t      pin_state,
   output logic                         state_valid
);
   import csd_pkg::*;

   // Probe sequence states
   typedef enum logic [1:0] {
      RS_IDLE,
      RS_UP,
      RS_DN
   } csd_rs_state_t;

   csd_rs_state_t            st_q,    st_d;       // Probe phase
   logic [CNT_W-1:0]         cnt_q,   cnt_d;      // Settle counter
   logic                     up_q,    up_d;       // Level seen under pull-up
   csd_pin_state_t           res_q,   res_d;      // Resolved state
   logic                     vld_q,   vld_d;      // At least one full scan

   localparam logic [CNT_W-1:0] LAST = CNT_W'(SETTLE - 1);

   // Next-state logic for the probe sequence
   always_comb begin
      st_d  = st_q;
      cnt_d = cnt_q;
      up_d  = up_q;
      res_d = res_q;
      vld_d = vld_q;
      case (st_q)
         RS_IDLE: begin
            // Serial use of the pin: no pulls, keep last decode
            cnt_d = '0;
            if (enable) begin
               st_d = RS_UP;
            end
         end
         RS_UP: begin
            if (!enable) begin
               st_d = RS_IDLE;
            end else if (cnt_q == LAST) begin
               up_d  = pin_sync;
               cnt_d = '0;
               st_d  = RS_DN;
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         RS_DN: begin
            if (!enable) begin
               st_d = RS_IDLE;
            end else if (cnt_q == LAST) begin
               cnt_d = '0;
               st_d  = RS_UP;
               // Compare the two probe results
               if (up_q && !pin_sync) begin
                  res_d = PS_FLOAT;
                  vld_d = 1'b1;
               end else if (up_q == pin_sync) begin
                  res_d = pin_sync ? PS_HIGH : PS_LOW;
                  vld_d = 1'b1;
               end
               // Up low / down high is a glitch: keep the old result
            end else begin
               cnt_d = cnt_q + 1'b1;
            end
         end
         default: begin
            st_d = RS_IDLE;
         end
      endcase
   end

   // State registers, frozen while ce is low
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         st_q  <= RS_IDLE;
         cnt_q <= '0;
         up_q  <= 1'b0;
         res_q <= PS_UNKNOWN;
         vld_q <= 1'b0;
      end else if (ce) begin
         st_q  <= st_d;
         cnt_q <= cnt_d;
         up_q  <= up_d;
         res_q <= res_d;
         vld_q <= vld_d;
      end
   end

   assign pull_up_en  = (st_q == RS_UP);
   assign pull_dn_en  = (st_q == RS_DN);
   assign pin_state   = res_q;
   assign state_valid = vld_q;

endmodule : csd_strap_resolver

// File: testbench/csd_pad_model.sv
// Purpose: Board straps and serial host seen at the configuration pads
// Assumes: Strap code 0 low, 1 high, 2 floating
// Notes:   An unpulled floating pad wanders every cycle
`timescale 1ns/1ps
module csd_pad_model (
   input  wire logic       mclk,
   input  wire logic [1:0] mode_sel,
   input  wire logic [1:0] amp_sel,
   input  wire logic [1:0] edge_sel,
   input  wire logic       host_sclk,
   input  wire logic       host_sdin,
   input  wire logic       host_cs_b,
   input  wire logic [5:0] pulls,
   output logic            mode_pin,
   output logic            amp_pin,
   output logic            edge_pin,
   output logic            cs_pin
);
   logic tgl_q = 1'b0;  // Stands in for an undriven level

   always_ff @(posedge mclk) tgl_q <= ~tgl_q;

   // Floating pad follows the weak pull, else wanders
   function automatic logic pad(input logic [1:0] sel, input logic up, input logic dn,
                                input logic t);
      if (sel == 2'h2) return up ? 1'b1 : (dn ? 1'b0 : t);
      return sel[0];  // Strap drives a firm level
   endfunction : pad

   assign mode_pin = pad(mode_sel, pulls[5], pulls[4], tgl_q);
   // Host owns the shared pins in serial control
   assign amp_pin  = (mode_sel == 2'h2) ? host_sclk : pad(amp_sel, pulls[3], pulls[2], tgl_q);
   assign edge_pin = (mode_sel == 2'h2) ? host_sdin : pad(edge_sel, pulls[1], pulls[0], tgl_q);
   assign cs_pin   = host_cs_b;
endmodule : csd_pad_model

// File: testbench/csd_strap_decoder_test.sv
// Purpose: Self-checking bench for the strap decoder
// Assumes: SETTLE of 4 keeps probe phases short
// Notes:   Each table row is decoded from a fresh reset
`timescale 1ns/1ps
module csd_strap_decoder_test;
   import csd_pkg::*;
   typedef struct packed {
      logic [1:0] m, a, e;
      logic       rng, swg, ris, ddr, ser;
   } csd_row_t;

   logic mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ce = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic [1:0] mode_sel = 2'h0, amp_sel = 2'h0, edge_sel = 2'h0;
   logic host_sclk = 1'b0, host_sdin = 1'b0, host_cs_b = 1'b0;
   logic mode_pin, amp_pin, edge_pin, cs_pin, config_valid, serial_mode, range_high;
   logic swing_high, edge_rising, ddr_enable, serial_clock, serial_data_input, csel_b;
   wire [5:0] pulls;  // mode up/dn, amp up/dn, edge up/dn
   int fails = 0, comparisons = 0;
   // Straps m,a,e then range, swing, rising, ddr, serial
   csd_row_t rows [5] = '{{2'h0, 2'h0, 2'h0, 5'b00000}, {2'h1, 2'h1, 2'h1, 5'b11100},
                          {2'h0, 2'h1, 2'h2, 5'b01010}, {2'h1, 2'h0, 2'h2, 5'b10010},
                          {2'h2, 2'h1, 2'h0, 5'b00001}};

   always #2.5 mclk = ~mclk;

   csd_strap_decoder #(.SETTLE(4)) u_csd_strap_decoder (
      .mclk(mclk), .rst_b(rst_b), .ce(ce), .mode_pin(mode_pin), .amp_pin(amp_pin),
      .edge_pin(edge_pin), .cs_pin(cs_pin), .mode_pull_up_en(pulls[5]),
      .mode_pull_dn_en(pulls[4]), .amp_pull_up_en(pulls[3]), .amp_pull_dn_en(pulls[2]),
      .edge_pull_up_en(pulls[1]), .edge_pull_dn_en(pulls[0]), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .config_valid(config_valid), .serial_mode(serial_mode), .range_high(range_high),
      .swing_high(swing_high), .edge_rising(edge_rising), .ddr_enable(ddr_enable),
      .serial_clock(serial_clock), .serial_data_input(serial_data_input),
      .serial_chip_select_b(csel_b));

   csd_pad_model u_csd_pad_model (
      .mclk(mclk), .mode_sel(mode_sel), .amp_sel(amp_sel), .edge_sel(edge_sel),
      .host_sclk(host_sclk), .host_sdin(host_sdin), .host_cs_b(host_cs_b), .pulls(pulls),
      .mode_pin(mode_pin), .amp_pin(amp_pin), .edge_pin(edge_pin), .cs_pin(cs_pin));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   // One-cycle strobes; read data sampled in the following cycle only
   task automatic reg_write(input logic [7:0] a, input logic [31:0] w);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= w;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
   endtask : reg_write

   task automatic reg_read(input logic [7:0] a, output logic [31:0] r);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask : reg_read

   // Set straps, reset, wait for a decode with a bound
   task automatic apply(input csd_row_t r);
      int n;
      @(posedge mclk);
      mode_sel <= r.m;
      amp_sel  <= r.a;
      edge_sel <= r.e;
      rst_b    <= 1'b0;
      repeat (2) @(posedge mclk);
      rst_b <= 1'b1;
      for (n = 0; n < 200 && config_valid !== 1'b1; n++) @(posedge mclk);
      check(n < 200, 1);
      repeat (4) @(posedge mclk);
      #1;
   endtask : apply

   task automatic conclude;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : conclude

   initial begin
      repeat (5000) @(posedge mclk);
      fails++;
      conclude();
   end

   initial begin
      @(posedge mclk);
      #1 check({config_valid, csel_b, pulls, reg_rdata[7:0]}, 16'h4000);
      @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      #1 check(pulls[5], 1);
      // Table: every strap code on the mode and edge pins; amplitude pin low and high only
      for (int i = 0; i < 5; i++) begin
         apply(rows[i]);
         check(range_high, rows[i].rng);
         check(swing_high, rows[i].swg);
         if (!rows[i].ddr) check(edge_rising, rows[i].ris);
         check(ddr_enable, rows[i].ddr);
         check(serial_mode, rows[i].ser);
         check(csel_b, !rows[i].ser);
         reg_read(OFS_STATUS, d);
         check({d[7:6], d[1:0]}, {rows[i].ser, 1'b1, rows[i].m});
         if (!rows[i].ser) check(d[5:2], {rows[i].e, rows[i].a});
         else check(d[5:2], 4'hf);
      end
      // Serial control: all host pin patterns pass through
      for (int k = 0; k < 8; k++) begin
         @(posedge mclk);
         host_sclk  <= k[0];
         host_sdin  <= k[1];
         host_cs_b  <= k[2];
         repeat (4) @(posedge mclk);
         #1 check({csel_b, serial_data_input, serial_clock, pulls[3:0]}, {k[2:0], 4'h0});
      end
      host_sclk <= 1'b0;
      apply(rows[1]);
      reg_read(OFS_CTRL, d);
      check(d, 32'h1);
      reg_read(8'h08, d);
      check(d, 32'h0);
      reg_write(8'h0c, 32'h0);
      reg_write(OFS_STATUS, 32'h0);
      reg_read(OFS_CTRL, d);
      check(d, 32'h1);
      // Probing off: pin changes must not reach the outputs
      reg_write(OFS_CTRL, 32'h0);
      reg_read(OFS_CTRL, d);
      check(d, 32'h0);
      // Clock enable low: a write must not land
      ce <= 1'b0;
      reg_write(OFS_CTRL, 32'h1);
      ce <= 1'b1;
      reg_read(OFS_CTRL, d);
      check(d, 32'h0);
      mode_sel <= 2'h0;
      amp_sel  <= 2'h2;
      edge_sel <= 2'h0;
      repeat (40) @(posedge mclk);
      #1 check({range_high, swing_high, pulls}, 8'hc0);
      // Probing on again; floating amplitude pin keeps the old swing
      reg_write(OFS_CTRL, 32'h1);
      repeat (60) @(posedge mclk);
      #1 check({range_high, swing_high, edge_rising, ddr_enable}, 4'h4);
      conclude();
   end
endmodule : csd_strap_decoder_test

// File: testbench/csd_strap_props.sv
// Purpose: Port-level assertions for the configuration strap decoder
// Assumes: ce high whenever pins are probed; probe phases last SETTLE cycles
// Notes:   Bound to every csd_strap_decoder instance
`timescale 1ns/1ps
module csd_strap_props #(
   parameter int unsigned SETTLE = csd_pkg::SETTLE_CYCLES
) (
   input wire logic                       mclk,
   input wire logic                       rst_b,
   input wire logic                       amp_pin,
   input wire logic                       edge_pin,
   input wire logic                       cs_pin,
   input wire logic                       mode_pull_up_en,
   input wire logic                       mode_pull_dn_en,
   input wire logic                       amp_pull_up_en,
   input wire logic                       amp_pull_dn_en,
   input wire logic                       edge_pull_up_en,
   input wire logic                       edge_pull_dn_en,
   input wire logic                       reg_rd,
   input wire logic [csd_pkg::DATA_W-1:0] reg_rdata,
   input wire logic                       config_valid,
   input wire logic                       serial_mode,
   input wire logic                       range_high,
   input wire logic                       swing_high,
   input wire logic                       edge_rising,
   input wire logic                       ddr_enable,
   input wire logic                       serial_clock,
   input wire logic                       serial_data_input,
   input wire logic                       serial_chip_select_b
);
   import csd_pkg::*;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   logic [7:0] up_cnt_q;  // Length of the current pull-up phase
   logic [7:0] up_cnt_d;

   // Count cycles of mode pull-up; a counter keeps SETTLE out of the repetition
   always_comb up_cnt_d = mode_pull_up_en ? up_cnt_q + 8'h01 : 8'h00;
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) up_cnt_q <= 8'h00;
      else        up_cnt_q <= up_cnt_d;
   end

   property p_pull_excl;
      !(mode_pull_up_en && mode_pull_dn_en) && !(amp_pull_up_en && amp_pull_dn_en)
         && !(edge_pull_up_en && edge_pull_dn_en);
   endproperty
   a_pull_excl: assert property (p_pull_excl) else $error("both pulls on one pin");
   property p_pull_len;
      $fell(mode_pull_up_en) && mode_pull_dn_en |-> up_cnt_q == 8'(SETTLE);
   endproperty
   a_pull_len: assert property (p_pull_len) else $error("pull-up phase length wrong");
   property p_serial_idle;
      !serial_mode && !$fell(serial_mode) |->
         !serial_clock && !serial_data_input && serial_chip_select_b;
   endproperty
   a_serial_idle: assert property (p_serial_idle) else $error("serial port active");
   property p_serial_pass;
      serial_mode && $past(serial_mode, 3) |-> serial_clock == $past(amp_pin, 3)
         && serial_data_input == $past(edge_pin, 3) && serial_chip_select_b == $past(cs_pin, 3);
   endproperty
   a_serial_pass: assert property (p_serial_pass) else $error("serial pin copy wrong");
   property p_probe_gate;
      serial_mode && $past(serial_mode) && $past(serial_mode, 2) |->
         !(amp_pull_up_en || amp_pull_dn_en || edge_pull_up_en || edge_pull_dn_en);
   endproperty
   a_probe_gate: assert property (p_probe_gate) else $error("shared pin probed");
   property p_cfg_src;
      $changed(swing_high) || $changed(edge_rising) || $changed(ddr_enable) |->
         $past(amp_pull_dn_en) || $past(amp_pull_dn_en, 2)
         || $past(edge_pull_dn_en) || $past(edge_pull_dn_en, 2);
   endproperty
   a_cfg_src: assert property (p_cfg_src) else $error("output changed off probe");
   property p_range_src;
      $changed(range_high) |-> $past(mode_pull_dn_en) || $past(mode_pull_dn_en, 2);
   endproperty
   a_range_src: assert property (p_range_src) else $error("range changed off probe");
   property p_rdata_idle;
      !$past(reg_rd) |-> reg_rdata == '0;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");

   c_pin_cfg: cover property ($rose(config_valid) && !serial_mode);
   c_serial:  cover property ($rose(serial_mode));
   c_ddr:     cover property ($rose(ddr_enable));
endmodule : csd_strap_props

bind csd_strap_decoder csd_strap_props #(.SETTLE(SETTLE)) u_csd_strap_props (
   .mclk(mclk), .rst_b(rst_b), .amp_pin(amp_pin), .edge_pin(edge_pin), .cs_pin(cs_pin),
   .mode_pull_up_en(mode_pull_up_en), .mode_pull_dn_en(mode_pull_dn_en),
   .amp_pull_up_en(amp_pull_up_en), .amp_pull_dn_en(amp_pull_dn_en),
   .edge_pull_up_en(edge_pull_up_en), .edge_pull_dn_en(edge_pull_dn_en),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .config_valid(config_valid),
   .serial_mode(serial_mode), .range_high(range_high), .swing_high(swing_high),
   .edge_rising(edge_rising), .ddr_enable(ddr_enable), .serial_clock(serial_clock),
   .serial_data_input(serial_data_input), .serial_chip_select_b(serial_chip_select_b));
